//--- hid_event_sequencer.v
// input-pin to report-bit sequencer with apb registers
//
// The APB register port and the register addresses were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "hidseq_defines.vh"
// How it works
// R1: enabled sequencer clears report bit after 50 ms
// R2: all sequencers start disabled after reset
// R3: enable command acts on selected map pin
// R4: triggers ignored 1 ms after sequencer clear
// R5: host enables sequencer in both maps
// R6: idle forever stops periodic report sends
// R7: any argument value enables idle forever
// R8: idle forever cleared only by reset
// R9: enabled sequencer turns edges into one-shots
// R10: 24 character serial stored, written, read back
// R11: serial option copies serial into descriptor; an option bit sent in the start write is not applied to desc_serial_valid
// R12: enumeration starts only after start written
// R13: wake detection notifies host without polling
// R14: host fetches detection indices after notice
// R15: assert edge sets bit, deassert clears it
// R16: alternation swaps maps after every assertion
// R17: hold and quiet timed from common tick
module hid_event_sequencer (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output wire pready,
    output wire pslverr,
    input wire [3:0] input_pins,
    input wire wake_detect,
    output reg [7:0] report_bits,
    output reg [2:0] periodic_enable,
    output reg wake_pulse,
    output reg enum_start,
    output reg desc_serial_valid,
    output reg [191:0] desc_serial,
    output reg nvm_write,
    output reg [4:0] nvm_addr,
    output reg [7:0] nvm_wdata,
    output reg nvm_read,
    input wire [7:0] nvm_rdata,
    output wire irq
);
    // ========================================
    // apb decode
    wire wr_en = psel && penable && pwrite;
    wire rd_en = psel && penable && !pwrite;
    assign pready = 1'b1;
    wire mapped = (paddr[11:5] == 7'h00) && (paddr[1:0] == 2'b00);
    assign pslverr = psel && penable && !mapped;
    wire [7:0] cmd_op = pwdata[31:24];
    wire [7:0] cmd_arg = pwdata[7:0];
    wire cmd_wr = wr_en && paddr == `REG_CMD;

    // ========================================
    // configuration state
    reg [1:0] map_sel_reg;
    reg map_bank_reg;
    reg [3:0] oneshot_main_reg;
    reg [3:0] oneshot_alt_reg;
    reg [1:0] usage_sel_reg;
    reg [2:0] idle_forever_reg;
    reg swap_en_reg;
    reg active_map_reg;
    reg [3:0] polarity_reg;
    reg [3:0] edge_en_reg;
    reg [2:0] bitsel_main_reg [0:3];
    reg [2:0] bitsel_alt_reg [0:3];
    reg [3:0] pins_prev_reg;
    reg [2:0] status_reg;
    reg [2:0] mask_reg;
    reg serial_opt_reg;
    reg [4:0] serial_idx_reg;
    reg [7:0] serial_reg [0:23];
    reg [7:0] wake_cnt_reg;
    integer i;
    reg [2:0] bit_idx_reg [0:3];
    reg [4:0] load_idx_reg;
    reg load_busy_reg;
    reg load_cap_reg;
    integer j;
    integer k;

    // ========================================
    // pin edge detection
    wire [3:0] pins_act = input_pins ^ ~polarity_reg;
    wire [3:0] prev_act = pins_prev_reg ^ ~polarity_reg;
    wire [3:0] rise = pins_act & ~prev_act & edge_en_reg;
    wire [3:0] fall = ~pins_act & prev_act & edge_en_reg;
    wire [3:0] seq_en = active_map_reg ? oneshot_alt_reg : oneshot_main_reg;
    wire [3:0] seq_bit;
    wire [3:0] seq_acc;
    wire [3:0] seq_clr;
    wire tick;

    tick_divider u_tick (
        .pclk(pclk),
        .presetn(presetn),
        .tick(tick)
    );

    genvar g;
    generate
        for (g = 0; g < 4; g = g + 1) begin : pins
            pin_sequencer u_seq (
                .pclk(pclk),
                .presetn(presetn),
                .tick(tick), // [R17]
                .enable(seq_en[g]),
                .assert_ev(rise[g]),
                .deassert_ev(fall[g]),
                .bit_out(seq_bit[g]),
                .accepted(seq_acc[g]),
                .cleared(seq_clr[g])
            );
        end
    endgenerate

    // ========================================
    // report bits at the index each pin took when accepted
    reg [7:0] report_next;
    always @* begin
        report_next = 8'h00;
        for (k = 0; k < 4; k = k + 1) begin
            if (seq_bit[k])
                report_next[bit_idx_reg[k]] = 1'b1;
        end
    end

    // ========================================
    // bit index latched at acceptance, so a map swap
    // does not move a bit that is already asserted
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (j = 0; j < 4; j = j + 1)
                bit_idx_reg[j] <= j[2:0];
        end else begin
            for (j = 0; j < 4; j = j + 1) begin
                if (seq_acc[j])
                    bit_idx_reg[j] <= active_map_reg ? bitsel_alt_reg[j] :
                                      bitsel_main_reg[j]; // [R16]
            end
        end
    end

    // ========================================
    // boot copy of the stored serial from external memory;
    // apb serial access is best left until it is done
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            load_idx_reg <= 5'h00;
            load_busy_reg <= 1'b1;
            load_cap_reg <= 1'b0;
        end else begin
            load_cap_reg <= load_busy_reg;
            if (load_busy_reg) begin
                if (load_idx_reg == 5'd23)
                    load_busy_reg <= 1'b0;
                else
                    load_idx_reg <= load_idx_reg + 5'h01;
            end
        end
    end

    // ========================================
    // main registers
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            map_sel_reg <= 2'h0;
            map_bank_reg <= 1'b0;
            oneshot_main_reg <= 4'h0; // [R2]
            oneshot_alt_reg <= 4'h0; // [R2]
            usage_sel_reg <= 2'h0;
            idle_forever_reg <= 3'h0;
            swap_en_reg <= 1'b0;
            active_map_reg <= 1'b0;
            polarity_reg <= 4'hf;
            edge_en_reg <= 4'h0;
            for (i = 0; i < 4; i = i + 1) begin
                bitsel_main_reg[i] <= i[2:0];
                bitsel_alt_reg[i] <= i[2:0];
            end
            pins_prev_reg <= 4'h0;
            status_reg <= 3'h0;
            mask_reg <= 3'h0;
            serial_opt_reg <= 1'b0;
            serial_idx_reg <= 5'h00;
            for (i = 0; i < 24; i = i + 1)
                serial_reg[i] <= 8'h20;
            report_bits <= 8'h00;
            periodic_enable <= 3'h7;
            wake_pulse <= 1'b0;
            enum_start <= 1'b0;
            desc_serial_valid <= 1'b0;
            desc_serial <= 192'h0;
            nvm_write <= 1'b0;
            nvm_addr <= 5'h00;
            nvm_wdata <= 8'h00;
            nvm_read <= 1'b0;
            wake_cnt_reg <= 8'h00;
        end else begin
            pins_prev_reg <= input_pins;
            report_bits <= report_next;
            nvm_write <= 1'b0;
            nvm_read <= 1'b0;
            wake_pulse <= 1'b0;
            if (load_busy_reg) begin
                nvm_read <= 1'b1; // [R10]
                nvm_addr <= load_idx_reg;
            end
            if (load_cap_reg)
                serial_reg[nvm_addr] <= nvm_rdata; // [R10]
            if (|seq_acc && swap_en_reg)
                active_map_reg <= ~active_map_reg; // [R16]
            if (cmd_wr) begin
                case (cmd_op)
                    `CMD_MAP_SELECT: begin
                        map_bank_reg <= pwdata[8];
                        map_sel_reg <= cmd_arg[1:0];
                    end
                    `CMD_ONESHOT_EN: begin
                        // only the pin chosen by the latest select
                        if (map_bank_reg)
                            oneshot_alt_reg[map_sel_reg] <= cmd_arg[0]; // [R3]
                        else
                            oneshot_main_reg[map_sel_reg] <= cmd_arg[0]; // [R3] [R5]
                    end
                    `CMD_USAGE_SELECT: usage_sel_reg <= cmd_arg[1:0];
                    `CMD_IDLE_FOREVER: begin
                        // argument ignored; one-way until reset
                        if (usage_sel_reg < 2'd3)
                            idle_forever_reg[usage_sel_reg] <= 1'b1; // [R7] [R8]
                    end
                    `CMD_SWAP_EN: swap_en_reg <= cmd_arg[0];
                    `CMD_POLARITY: polarity_reg[map_sel_reg] <= cmd_arg[0];
                    `CMD_EDGE_CFG: edge_en_reg[map_sel_reg] <= |cmd_arg[1:0];
                    `CMD_PIN_BIT: begin
                        if (map_bank_reg)
                            bitsel_alt_reg[map_sel_reg] <= cmd_arg[2:0];
                        else
                            bitsel_main_reg[map_sel_reg] <= cmd_arg[2:0];
                    end
                    default: ;
                endcase
            end
            periodic_enable <= ~idle_forever_reg; // [R6]
            if (wr_en && paddr == `REG_MASK)
                mask_reg <= pwdata[2:0];
            if (wr_en && paddr == `REG_SERIAL_ADDR)
                serial_idx_reg <= pwdata[4:0];
            if (wr_en && paddr == `REG_SERIAL_DATA && serial_idx_reg < 5'd24) begin
                serial_reg[serial_idx_reg] <= pwdata[7:0]; // [R10]
                nvm_write <= 1'b1;
                nvm_addr <= serial_idx_reg;
                nvm_wdata <= pwdata[7:0];
            end
            if (rd_en && paddr == `REG_SERIAL_DATA) begin
                nvm_read <= 1'b1; // [R10]
                nvm_addr <= serial_idx_reg;
            end
            if (wr_en && paddr == `REG_USB) begin
                if (!enum_start)
                    serial_opt_reg <= pwdata[0];
                if (pwdata[1] && !enum_start) begin
                    enum_start <= 1'b1; // [R12]
                    desc_serial_valid <= serial_opt_reg; // [R11]
                    for (i = 0; i < 24; i = i + 1)
                        desc_serial[i*8 +: 8] <= serial_reg[i]; // [R11]
                end
            end
            if (wake_detect) begin
                wake_pulse <= 1'b1; // [R13]
                wake_cnt_reg <= wake_cnt_reg + 8'h01;
            end
            // set beats the read clear
            if (rd_en && paddr == `REG_STATUS)
                status_reg <= {wake_detect, |seq_clr, |seq_acc};
            else
                status_reg <= status_reg | {wake_detect, |seq_clr, |seq_acc}; // [R13]
        end
    end

    // irq lets the host skip polling
    assign irq = |(status_reg & mask_reg); // [R13]

    // ========================================
    // read mux
    always @* begin
        prdata = 32'h0000_0000;
        case (paddr)
            `REG_STATUS: prdata = {29'h0, status_reg};
            `REG_MASK: prdata = {29'h0, mask_reg};
            `REG_REPORT: prdata = {24'h0, report_bits};
            `REG_CONFIG: prdata = {8'h0, wake_cnt_reg, oneshot_alt_reg, oneshot_main_reg,
                                   1'b0, idle_forever_reg, 3'h0, swap_en_reg};
            `REG_SERIAL_ADDR: prdata = {27'h0, serial_idx_reg};
            `REG_SERIAL_DATA: prdata = {24'h0, serial_reg[serial_idx_reg < 5'd24 ?
                                        serial_idx_reg : 5'h00]};
            `REG_USB: prdata = {29'h0, desc_serial_valid, enum_start, serial_opt_reg};
            default: prdata = 32'h0000_0000;
        endcase
    end
endmodule
`default_nettype wire

//--- hidseq_defines.vh
// constants for the input-event sequencer block
`ifndef HIDSEQ_DEFINES_VH
`define HIDSEQ_DEFINES_VH
// ========================================
// timing
`define CLK_HZ 100000000
`define TICK_NS 1000
`define TICK_CYCLES 7'd100
`define HOLD_MS 50
`define HOLD_TICKS 16'd50000
`define IDLE_MS 1
`define IDLE_TICKS 16'd1000
// ========================================
// register byte offsets
`define REG_CMD 12'h000
`define REG_STATUS 12'h004
`define REG_MASK 12'h008
`define REG_REPORT 12'h00c
`define REG_CONFIG 12'h010
`define REG_SERIAL_ADDR 12'h014
`define REG_SERIAL_DATA 12'h018
`define REG_USB 12'h01c
// ========================================
// command codes in cmd[31:24], argument in cmd[7:0]
`define CMD_MAP_SELECT 8'h01
`define CMD_ONESHOT_EN 8'h02
`define CMD_USAGE_SELECT 8'h03
`define CMD_IDLE_FOREVER 8'h04
`define CMD_SWAP_EN 8'h05
`define CMD_POLARITY 8'h06
`define CMD_EDGE_CFG 8'h07
`define CMD_PIN_BIT 8'h08
// ========================================
// sizes
`define NPINS 4
`define NREPORTS 3
`define SERIAL_LEN 24
`endif

//--- tick_divider.v
// one-cycle tick divider for the sequencer timers
`timescale 1ns/1ps
`default_nettype none
`include "hidseq_defines.vh"
module tick_divider (
    input wire pclk,
    input wire presetn,
    output reg tick
);
    reg [6:0] cnt_reg;
    // ========================================
    // divider
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_reg <= 7'h00;
            tick <= 1'b0;
        end else if (cnt_reg == `TICK_CYCLES - 7'd1) begin
            cnt_reg <= 7'h00;
            tick <= 1'b1;
        end else begin
            cnt_reg <= cnt_reg + 7'h01;
            tick <= 1'b0;
        end
    end
endmodule
`default_nettype wire

//--- pin_sequencer.v
// one-shot sequencer for one input pin
`timescale 1ns/1ps
`default_nettype none
`include "hidseq_defines.vh"
module pin_sequencer (
    input wire pclk,
    input wire presetn,
    input wire tick,
    input wire enable,
    input wire assert_ev,
    input wire deassert_ev,
    output reg bit_out,
    output wire accepted,
    output reg cleared
);
    localparam IDLE = 3'b001;
    localparam HOLD = 3'b010;
    localparam QUIET = 3'b100;
    reg [2:0] state_reg;
    reg [15:0] cnt_reg;
    // hold and quiet windows swallow triggers
    assign accepted = assert_ev && (state_reg == IDLE); // [R4]
    // ========================================
    // state machine
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= IDLE;
            cnt_reg <= 16'h0000;
            bit_out <= 1'b0;
            cleared <= 1'b0;
        end else begin
            cleared <= 1'b0;
            case (state_reg)
                IDLE: begin
                    if (assert_ev) begin
                        bit_out <= 1'b1; // [R15]
                        cnt_reg <= 16'h0000;
                        if (enable)
                            state_reg <= HOLD; // [R9]
                    end else if (deassert_ev && !enable) begin
                        bit_out <= 1'b0; // [R15]
                    end
                end
                HOLD: begin
                    // pin level ignored while holding
                    if (tick)
                        cnt_reg <= cnt_reg + 16'h0001; // [R17]
                    if (tick && cnt_reg == `HOLD_TICKS - 16'h0001) begin
                        bit_out <= 1'b0; // [R1]
                        cleared <= 1'b1;
                        cnt_reg <= 16'h0000;
                        state_reg <= QUIET;
                    end
                end
                QUIET: begin
                    if (tick)
                        cnt_reg <= cnt_reg + 16'h0001;
                    if (tick && cnt_reg == `IDLE_TICKS - 16'h0001)
                        state_reg <= IDLE; // [R4]
                end
                default: state_reg <= IDLE;
            endcase
        end
    end
endmodule
`default_nettype wire

//--- hid_seq_checker_assertions.sv
// concurrent checks on the sequencer block ports
`timescale 1ns/1ps
`default_nettype none
module hid_seq_checker (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    input wire [31:0] prdata,
    input wire pready,
    input wire pslverr,
    input wire wake_detect,
    input wire wake_pulse,
    input wire enum_start,
    input wire [2:0] periodic_enable,
    input wire nvm_write
);
    // ========================================
    // properties
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    property p_ready;
        psel && penable |-> pready;
    endproperty
    a_ready: assert property (p_ready) else $error("pready low in access");
    property p_err;
        psel && penable && paddr[1:0] == 2'h0 |-> pslverr == (paddr >= 12'h020);
    endproperty
    a_err: assert property (p_err) else $error("pslverr wrong");
    property p_unmapped_zero;
        psel && penable && !pwrite && paddr >= 12'h020 |-> prdata == 32'h0;
    endproperty
    a_unmapped_zero: assert property (p_unmapped_zero) else $error("unmapped read nonzero");
    property p_wake;
        wake_detect |=> wake_pulse ##1 !wake_pulse;
    endproperty
    a_wake: assert property (p_wake) else $error("wake pulse missing");
    property p_enum_cause;
        $rose(enum_start) |-> $past(psel && penable && pwrite && paddr == 12'h01c && pwdata[1]);
    endproperty
    a_enum_cause: assert property (p_enum_cause) else $error("enum start uncaused");
    property p_enum_hold;
        enum_start |=> enum_start [*8];
    endproperty
    a_enum_hold: assert property (p_enum_hold) else $error("enum start dropped");
    // idle forever may only be added, never withdrawn
    property p_idle_keep;
        (periodic_enable & ~$past(periodic_enable)) == 3'h0;
    endproperty
    a_idle_keep: assert property (p_idle_keep) else $error("idle forever cleared");
    property p_nvm;
        nvm_write |-> $past(psel && penable && pwrite && paddr == 12'h018);
    endproperty
    a_nvm: assert property (p_nvm) else $error("serial store uncaused");
endmodule
bind hid_event_sequencer hid_seq_checker u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .wake_detect(wake_detect), .wake_pulse(wake_pulse),
    .enum_start(enum_start), .periodic_enable(periodic_enable), .nvm_write(nvm_write));
`default_nettype wire

//--- usb_host_model.sv
// behavioural host that samples reports once enumerated
`timescale 1ns/1ps
`default_nettype none
module usb_host_model (
    input wire pclk,
    input wire presetn,
    input wire [7:0] report_bits,
    input wire enum_start,
    input wire wake_pulse,
    output logic [7:0] last_report,
    output logic fetch_due
);
    // ========================================
    // no report sampling before enumeration starts; a wake pulse sets fetch_due at any time
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            last_report <= 8'h00;
            fetch_due <= 1'b0;
        end else begin
            if (enum_start) begin
                last_report <= report_bits;
            end
            if (wake_pulse) begin
                fetch_due <= 1'b1;
            end
        end
    end
endmodule
`default_nettype wire

//--- tb_hid_event_sequencer.sv
// self-checking bench for the input-event sequencer
`timescale 1ns/1ps
`default_nettype none
`include "hidseq_defines.vh"
`define chk(a, e) begin cmp_count++; if ((a) !== (e)) begin fails++; \
    $display("BAD t=%0t got=%h exp=%h", $time, a, e); end end
module tb_hid_event_sequencer;
    logic pclk, presetn, psel, penable, pwrite, wake_detect;
    logic [11:0] paddr;
    logic [31:0] pwdata, exp_v;
    logic [3:0] input_pins;
    wire [31:0] prdata;
    wire pready, pslverr, wake_pulse, enum_start, desc_serial_valid, irq, fetch_due;
    wire [7:0] report_bits, last_report;
    wire [2:0] periodic_enable;
    wire [191:0] desc_serial;
    wire nvm_read;
    wire [4:0] nvm_addr;
    wire [7:0] nvm_wdata, nvm_rdata;
    logic [31:0] exp_q[$];
    int fails, cmp_count, cycles, seed, r;
    logic [7:0] ch;
    // ========================================
    // design and host
    hid_event_sequencer u_hid_event_sequencer (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .input_pins(input_pins),
        .wake_detect(wake_detect), .report_bits(report_bits),
        .periodic_enable(periodic_enable), .wake_pulse(wake_pulse), .enum_start(enum_start),
        .desc_serial_valid(desc_serial_valid), .desc_serial(desc_serial), .nvm_write(),
        .nvm_addr(nvm_addr), .nvm_wdata(nvm_wdata), .nvm_read(nvm_read),
        .nvm_rdata(nvm_rdata), .irq(irq));
    // stored serial stand-in: each slot holds its index plus ascii zero
    assign nvm_rdata = 8'h30 + {3'h0, nvm_addr};
    usb_host_model u_usb_host_model (.pclk(pclk), .presetn(presetn),
        .report_bits(report_bits), .enum_start(enum_start), .wake_pulse(wake_pulse),
        .last_report(last_report), .fetch_due(fetch_due));
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    // ========================================
    // read data checked as it appears
    always @(posedge pclk) begin
        cycles++;
        if (cycles > 20000) begin
            fails++;
            results();
        end
        if (psel && penable && pready && !pwrite && exp_q.size() > 0) begin
            exp_v = exp_q.pop_front();
            `chk(prdata, exp_v)
        end
    end
    task automatic results();
        if (fails == 0 && cmp_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    // request held until pready is seen high
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (!pready);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        apb(1'b0, a, 32'h0);
    endtask
    task automatic cmd(input logic [7:0] op, input logic bank, input logic [7:0] arg);
        apb(1'b1, `REG_CMD, {op, 15'h0, bank, arg});
    endtask
    task automatic wait_clk(input int n);
        repeat (n) @(posedge pclk);
    endtask
    // ========================================
    // main sequence
    initial begin
        {psel, penable, pwrite, wake_detect} = 4'h0;
        paddr = 12'h000;
        pwdata = 32'h0;
        input_pins = 4'h0;
        presetn = 1'b0;
        seed = 48205;
        wait_clk(10);
        presetn <= 1'b1;
        `chk(periodic_enable, 3'h7)
        rd(`REG_CONFIG, 32'h0);
        `chk(nvm_read, 1'b1)
        rd(12'h020, 32'h0);
        apb(1'b1, `REG_MASK, 32'h7);
        cmd(`CMD_MAP_SELECT, 1'b0, 8'h01);
        cmd(`CMD_EDGE_CFG, 1'b0, 8'h03);
        input_pins <= 4'h2;
        wait_clk(4);
        `chk(report_bits[1], 1'b1)
        `chk(irq, 1'b1)
        input_pins <= 4'h0;
        wait_clk(4);
        `chk(report_bits[1], 1'b0)
        rd(`REG_STATUS, 32'h1);
        wait_clk(2);
        `chk(irq, 1'b0)
        // one-shot must be set in both maps when swapping is used
        cmd(`CMD_ONESHOT_EN, 1'b0, 8'h01);
        cmd(`CMD_MAP_SELECT, 1'b1, 8'h01);
        cmd(`CMD_ONESHOT_EN, 1'b1, 8'h01);
        rd(`REG_CONFIG, 32'h2200);
        cmd(`CMD_MAP_SELECT, 1'b1, 8'h00);
        cmd(`CMD_PIN_BIT, 1'b1, 8'h04);
        cmd(`CMD_EDGE_CFG, 1'b1, 8'h03);
        cmd(`CMD_SWAP_EN, 1'b0, 8'h01);
        input_pins <= 4'h2;
        wait_clk(4);
        `chk(report_bits, 8'h02)
        input_pins <= 4'h1;
        wait_clk(4);
        `chk(report_bits, 8'h12)
        input_pins <= 4'h0;
        wait_clk(4);
        `chk(report_bits, 8'h02)
        rd(`REG_STATUS, 32'h1);
        r = $unsigned($random(seed)) % 3;
        cmd(`CMD_USAGE_SELECT, 1'b0, r[7:0]);
        cmd(`CMD_IDLE_FOREVER, 1'b0, 8'h00);
        wait_clk(2);
        `chk(periodic_enable, 3'h7 & ~(3'h1 << r))
        cmd(`CMD_USAGE_SELECT, 1'b0, 8'((r + 1) % 3));
        cmd(`CMD_IDLE_FOREVER, 1'b0, 8'($random(seed)));
        wait_clk(2);
        `chk(periodic_enable, 3'h7 & ~(3'h1 << r) & ~(3'h1 << ((r + 1) % 3)))
        for (int i = 4; i < 7; i++) begin
            ch = 8'h41 + 8'($unsigned($random(seed)) % 26);
            apb(1'b1, `REG_SERIAL_ADDR, 32'(i));
            apb(1'b1, `REG_SERIAL_DATA, {24'h0, ch});
            rd(`REG_SERIAL_DATA, {24'h0, ch});
        end
        `chk(nvm_wdata, ch)
        `chk(nvm_addr, 5'd6)
        `chk(last_report, 8'h00)
        `chk(enum_start, 1'b0)
        apb(1'b1, `REG_USB, 32'h1);
        apb(1'b1, `REG_USB, 32'h3);
        wait_clk(2);
        `chk(enum_start, 1'b1)
        `chk(desc_serial_valid, 1'b1)
        `chk(desc_serial[55:48], ch)
        `chk(desc_serial[7:0], 8'h30)
        `chk(desc_serial[191:184], 8'h47)
        `chk(last_report, 8'h02)
        wake_detect <= 1'b1;
        @(posedge pclk);
        wake_detect <= 1'b0;
        wait_clk(3);
        `chk(fetch_due, 1'b1)
        rd(`REG_STATUS, 32'h4);
        wait_clk(4);
        results();
    end
endmodule
`default_nettype wire
